// >>> core/armef_pkg.sv
package armef_pkg;
    // register map
    localparam logic [7:0] ENTRY_BASE     = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h40;
    localparam int         ADDR_W         = 8;
    localparam int         ENTRY_CNT      = 16;
    localparam int         ENTRY_IDX_W    = 4;
    // entry field layout
    localparam int         PORT_LSB       = 0;
    localparam int         PORT_W         = 8;
    localparam int         DTYPE_BIT      = 9;
    localparam int         AGG_LSB        = 10;
    localparam int         AGG_W          = 4;
    localparam int         RSVD_BIT       = 14;
    localparam int         LINK_LSB       = 15;
    localparam int         LINK_W         = 6;
    // reset values
    localparam logic [3:0] AGG_RESET      = 4'h0;
    localparam logic [5:0] LINK_RESET     = 6'h00;
    localparam logic [31:0] ENTRY_RESET   = 32'h0000_0000;
    // writable bits: port, dest type, count, preserved bit 14, link
    localparam logic [31:0] ENTRY_WMASK   = 32'h001F_FEFF;
    // status layout
    localparam int         ST_BAD_LSB     = 0;
    localparam int         ST_FLR_BIT     = 16;
endpackage

// >>> core/armef_entry_mem.sv
`timescale 1ns/10ps
`default_nettype none
module armef_entry_mem
    import armef_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          sys_rst,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [31:0]   wr_data,
    // read port
    input  wire logic [AW-1:0] rd_idx,
    output var  logic [31:0]   rd_data
);
    logic [31:0] mem [DEPTH];

    // function level reset never reaches here: only sys_rst clears
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= ENTRY_RESET; // R07 R10
            end
        end else if (wr_en) begin
            mem[wr_idx] <= wr_data & ENTRY_WMASK; // R08 R13
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_data <= ENTRY_RESET;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// >>> core/armef_top.sv
// Behaviour
// R01: count zero means aggregation off
// R02: aggregation off: port field is sole port
// R03: ports used equal count plus one
// R04: only counts 1,3,7,15 aggregate ports
// R05: software programs only 0,1,3,7,15
// R06: aggregation on: port field starts group
// R07: count clears on reset, not function reset
// R08: six bit link number field, read write
// R09: software sets same link on all members
// R10: link clears on reset, not function reset
// R11: link zero when destination type zero
// R12: count zero when destination type zero
// R13: bit 14 preserved, no effect
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module armef_top
(
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // function level reset pulse, leaves entries alone
    input  wire logic                     function_level_reset,
    // register port
    input  wire logic [armef_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    // lookup of one agent identifier
    input  wire logic [armef_pkg::ENTRY_IDX_W-1:0] lookup_agent,
    output logic      [armef_pkg::PORT_W-1:0]      first_port_of_group,
    output logic      [4:0]               port_group_size,
    output logic      [armef_pkg::LINK_W-1:0]      agent_link_number,
    output logic                          agent_destination_type,
    output logic                          count_invalid
);
    import armef_pkg::*;

    // only the five documented counts are legal
    function automatic logic count_legal(input logic [AGG_W-1:0] c);
        case (c)
            4'h0, 4'h1, 4'h3, 4'h7, 4'hF: return 1'b1; // R04
            default:                      return 1'b0;
        endcase
    endfunction

    // ports in the group; reserved counts fall back to one port
    function automatic logic [4:0] group_size(input logic [AGG_W-1:0] c);
        if (count_legal(c)) begin
            return {1'b0, c} + 5'h01; // R01 R03 R04
        end else begin
            return 5'h01; // R04
        end
    endfunction

    function automatic logic is_entry(input logic [ADDR_W-1:0] a);
        return (a[7:6] == ENTRY_BASE[7:6]) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_status(input logic [ADDR_W-1:0] a);
        return a == STATUS_OFS;
    endfunction

    // one word per entry, so the index sits above the byte bits
    function automatic logic [ENTRY_IDX_W-1:0] entry_idx(
        input logic [ADDR_W-1:0] a
    );
        return a[2 +: ENTRY_IDX_W];
    endfunction

    // reserved-count flags low, function reset seen just above
    function automatic logic [31:0] pack_status(
        input logic                 seen,
        input logic [ENTRY_CNT-1:0] bad
    );
        return {15'h0000, seen, bad};
    endfunction

    logic                   wr_entry;
    logic                   wr_status;
    logic                   rd_entry;
    logic                   rd_status;
    logic [ENTRY_IDX_W-1:0] mem_rd_idx;
    logic [31:0]            mem_rd_data;
    logic                   rd_was_entry;
    logic [31:0]            rd_other;
    logic                   lookup_phase;
    logic [ENTRY_CNT-1:0]   bad_count;
    logic                   flr_seen;
    logic [AGG_W-1:0]       agg;
    logic [31:0]            status_word;

    assign wr_entry    = reg_wr && is_entry(reg_addr);
    assign wr_status   = reg_wr && is_status(reg_addr);
    assign rd_entry    = reg_rd && is_entry(reg_addr);
    assign rd_status   = reg_rd && is_status(reg_addr);
    // software reads take the read port; lookups use it otherwise
    assign mem_rd_idx  = reg_rd ? entry_idx(reg_addr) : lookup_agent;
    assign agg         = mem_rd_data[AGG_LSB +: AGG_W];
    assign status_word = pack_status(flr_seen, bad_count);

    // writes to unmapped words never reach the memory
    armef_entry_mem #(
        .DEPTH (ENTRY_CNT),
        .AW    (ENTRY_IDX_W)
    ) u_mem (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_entry),
        .wr_idx  (entry_idx(reg_addr)),
        .wr_data (reg_wdata),
        .rd_idx  (mem_rd_idx),
        .rd_data (mem_rd_data)
    );

    // remember that the strobe read an entry
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_was_entry <= 1'b0;
        end else begin
            rd_was_entry <= rd_entry;
        end
    end

    // status reads captured here; unmapped reads and idle give zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_other <= 32'h0000_0000;
        end else if (rd_status) begin
            rd_other <= status_word;
        end else begin
            rd_other <= 32'h0000_0000;
        end
    end

    // entry data come straight off the memory's read register: a
    // second flop here would push the reply a cycle late
    assign reg_rdata = rd_was_entry ? mem_rd_data : rd_other; // R13

    // a read steals the port for one cycle, so the lookup result
    // is simply held through the cycle after it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lookup_phase <= 1'b0;
        end else begin
            lookup_phase <= !reg_rd;
        end
    end

    // per-entry flag of a reserved count, tracked on write;
    // a later legal write to the same entry clears it again
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bad_count <= '0;
        end else if (wr_entry) begin
            bad_count[entry_idx(reg_addr)] <=
                !count_legal(reg_wdata[AGG_LSB +: AGG_W]);
        end
    end

    // sticky record that a function level reset happened;
    // a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flr_seen <= 1'b0;
        end else if (function_level_reset) begin
            flr_seen <= 1'b1; // R07 R10
        end else if (wr_status && reg_wdata[ST_FLR_BIT]) begin
            flr_seen <= 1'b0;
        end
    end

    // port field is sole port or base of a linear group
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            first_port_of_group <= '0;
        end else if (lookup_phase) begin
            first_port_of_group <= mem_rd_data[PORT_LSB +: PORT_W]; // R02 R06
        end
    end

    // link number passes through untouched
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            agent_link_number <= LINK_RESET; // R10
        end else if (lookup_phase) begin
            agent_link_number <= mem_rd_data[LINK_LSB +: LINK_W]; // R08
        end
    end

    // destination type is shown as stored; software keeps the
    // count and link at zero when it is clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            agent_destination_type <= 1'b0;
        end else if (lookup_phase) begin
            agent_destination_type <= mem_rd_data[DTYPE_BIT];
        end
    end

    // count zero or legal count: count plus one ports; reserved
    // counts give one port rather than a group of odd size
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_group_size <= 5'h01; // R07
        end else if (lookup_phase) begin
            port_group_size <= group_size(agg); // R01 R03 R04
        end
    end

    // reserved counts are stored as written, so they are
    // flagged here instead of being refused on write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            count_invalid <= 1'b0;
        end else if (lookup_phase) begin
            count_invalid <= !count_legal(agg); // R04
        end
    end
endmodule
`default_nettype wire

// >>> bench/armef_checker.sv
`timescale 1ns/10ps
`default_nettype none
module armef_checker (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // observed ports
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0]  lookup_agent,
    input wire logic [7:0]  first_port_of_group,
    input wire logic [4:0]  port_group_size,
    input wire logic [5:0]  agent_link_number,
    input wire logic        agent_destination_type,
    input wire logic        count_invalid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // lookup only trusted once the port has been quiet
    sequence quiet_rd;
        (!reg_wr && !reg_rd && $stable(lookup_agent))[*4]
        ##1 (reg_rd && reg_addr == {2'b00, lookup_agent, 2'b00});
    endsequence
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    chk_rsvd_zero: assert property (
        $past(reg_rd && reg_addr < 8'h40)
        |-> reg_rdata[31:21] == 11'h0 && !reg_rdata[8])
        else $error("reserved entry bits not zero");
    chk_inv_single: assert property (
        count_invalid |-> port_group_size == 5'h01)
        else $error("reserved count not single port");
    chk_size_pow: assert property (
        port_group_size inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        else $error("group size not a power of two");
    chk_reset_val: assert property (
        $past(sys_rst) |-> port_group_size == 5'h01
        && agent_link_number == 6'h00)
        else $error("lookup not cleared by reset");
    chk_link_map: assert property (
        quiet_rd |=> reg_rdata[20:15] == $past(agent_link_number))
        else $error("link number differs from entry");
    chk_port_map: assert property (
        quiet_rd |=> reg_rdata[7:0] == $past(first_port_of_group)
        && reg_rdata[9] == $past(agent_destination_type))
        else $error("port differs from entry");
    chk_size_cnt: assert property (
        quiet_rd |=> $past(port_group_size) ==
        (reg_rdata[13:10] inside {1, 3, 7, 15} ?
        reg_rdata[13:10] + 5'h01 : 5'h01))
        else $error("group size differs from count");
    chk_inv_flag: assert property (
        quiet_rd |=> $past(count_invalid) ==
        !(reg_rdata[13:10] inside {0, 1, 3, 7, 15}))
        else $error("invalid flag differs from count");
endmodule
bind armef_top armef_checker chk (.ref_clk, .sys_rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_rdata, .lookup_agent, .first_port_of_group,
    .port_group_size, .agent_link_number, .agent_destination_type,
    .count_invalid);
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    n_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
    import armef_pkg::*;
    logic        ref_clk = 0, sys_rst = 1, function_level_reset = 0;
    logic        reg_wr = 0, reg_rd = 0, agent_destination_type;
    logic        count_invalid;
    logic [7:0]  reg_addr = 8'h00, first_port_of_group;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d, dat;
    logic [3:0]  lookup_agent = 4'h0;
    logic [4:0]  port_group_size;
    logic [5:0]  agent_link_number;
    int          n_errors = 0, check_count = 0;
    // entry word beside the group size it should give; only row 5
    // holds a reserved count, to see the fallback
    logic [36:0] rows [7] = '{{32'h0000_0205, 5'h01},
        {32'h0000_0611, 5'h02}, {32'h001F_8EFF, 5'h04},
        {32'h0000_5E00, 5'h08}, {32'h0000_BE03, 5'h10},
        {32'hFFE0_0B00, 5'h01}, {32'h0000_0033, 5'h01}};
    armef_top uut (.ref_clk, .sys_rst, .function_level_reset, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lookup_agent,
        .first_port_of_group, .port_group_size, .agent_link_number,
        .agent_destination_type, .count_invalid);
    always #5 ref_clk = ~ref_clk;
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // lookup needs a few quiet cycles to settle
    task look(input logic [3:0] i);
        @(posedge ref_clk) lookup_agent <= i;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #50000 n_errors++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h00);
        `CHK("reset entry", 32'h0, d)
        for (int i = 0; i < 7; i++) begin
            dat = rows[i][36:5];
            wr(8'(i * 4), dat);
            look(4'(i));
            `CHK("port", dat[7:0], first_port_of_group)
            `CHK("size", rows[i][4:0], port_group_size)
            `CHK("link", dat[20:15], agent_link_number)
            `CHK("dtype", dat[9], agent_destination_type)
            `CHK("inv", rows[i][4:0] == 1 && dat[13:10] != 0, count_invalid)
            rd(8'(i * 4));
            `CHK("readback", dat & ENTRY_WMASK, d)
        end
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80);
        `CHK("unmapped", 32'h0, d)
        @(posedge ref_clk) function_level_reset <= 1'b1;
        @(posedge ref_clk) function_level_reset <= 1'b0;
        rd(8'h08);
        `CHK("flr keeps", 32'h001F_8EFF, d)
        rd(STATUS_OFS);
        `CHK("flr seen", 1'b1, d[ST_FLR_BIT])
        `CHK("bad flags", 16'h0020, d[15:0])
        wr(STATUS_OFS, 32'h0001_0000);
        rd(STATUS_OFS);
        `CHK("flr clear", 1'b0, d[ST_FLR_BIT])
        @(posedge ref_clk) sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h08);
        `CHK("rst entry", 32'h0, d)
        look(4'h2);
        `CHK("rst size", 5'h01, port_group_size)
        `CHK("rst link", 6'h00, agent_link_number)
        wrap_up;
    end
endmodule
`default_nettype wire
